// ---- src/pgc_gate_timing.sv ----
// pgc_gate_timing: gate control waveform generator with wishbone registers
// Function
// - shift clock edges programmed around line load
// - shift clock idle until start delay elapses
// - output enable edges programmed around line load
// - output enable idle polarity is programmable
// - two strobes, programmable line and width
// - two general outputs with selectable roles
// - converter start rises after programmed delay
// - strap low selects gray test patterns
// - strap sampled once after reset only
// - recovered clock presented on output pin
// - spread clock input unused; output side runs from mclk
// - loop-back selects recovered clock internally
// - test pin high means test mode
// - line load rises after line shifted out
// assumes mclk is the dot clock already chosen by the clock mux outside; srst is power-on reset
`timescale 1ns/100ps
`default_nettype none
module pgc_gate_timing
  import pgc_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic lineDone,
  input wire logic frameStart,
  input wire logic burnInPatternStrap,
  input wire logic testPin,
  input wire logic recoveredClockIn,
  input wire logic spreadClockInput,
  output logic lineLoadPulse,
  output pgc_pkg::pgc_gate_t gateOut,
  output logic patternMode,
  output logic testMode,
  output logic recoveredClockOutput,
  output logic recoveredClockOutputEn,
  output logic dotClockSelect
);
  import pgc_pkg::*;

  initial begin
    if (W < 8 || W > 16) $error("pgc_gate_timing: W out of range");
  end

  // registers
  logic [31:0] ctrl, lineCfg, sclkCfg, oenCfg, stbaCfg, stbbCfg, gpo1Cfg, gpo2Cfg, startCfg;

  // pin synchronisers
  logic [1:0] syncDone, syncFrame, syncStrap, syncTest;
  always_ff @(posedge mclk) begin
    syncDone <= {syncDone[0], lineDone};
    syncFrame <= {syncFrame[0], frameStart};
    syncStrap <= {syncStrap[0], burnInPatternStrap};
    syncTest <= {syncTest[0], testPin};
  end
  wire lineDoneS = syncDone[1];
  wire frameS = syncFrame[1];
  logic lineDoneD, frameD;
  wire lineDoneRise = lineDoneS & ~lineDoneD;
  wire frameRise = frameS & ~frameD;

  // strap capture after reset release
  logic strapTaken;
  always_ff @(posedge mclk) begin
    if (srst) begin
      strapTaken <= 1'b0;
      patternMode <= 1'b0;
    end else if (!strapTaken) begin
      strapTaken <= 1'b1;
      patternMode <= ~syncStrap[1];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      testMode <= 1'b0;
    end else begin
      testMode <= syncTest[1];
    end
  end

  // clock routing controls
  wire loopback = ctrl[CTRL_LOOPBACK];
  assign dotClockSelect = loopback;
  assign recoveredClockOutput = loopback ? 1'b0 : recoveredClockIn;
  assign recoveredClockOutputEn = ~loopback;
  wire unusedSpread = spreadClockInput;

  // line position counter, zero at line load rise
  localparam logic signed [W-1:0] POS_ZERO = '0;
  localparam logic signed [W-1:0] POS_MAX = {1'b0, {(W-1){1'b1}}};
  localparam logic signed [W-1:0] POS_ONE = {{(W-1){1'b0}}, 1'b1};
  logic signed [W-1:0] pos;
  wire [W-1:0] llWidth = lineCfg[W-1:0];
  wire [W-1:0] llDelay = lineCfg[16 +: W];
  logic [W-1:0] llCnt;
  logic llPending;

  function automatic logic [W-1:0] incSat(input logic [W-1:0] v);
    incSat = (v == {W{1'b1}}) ? v : v + 1'b1;
  endfunction : incSat

  always_ff @(posedge mclk) begin
    lineDoneD <= srst ? 1'b0 : lineDoneS;
    frameD <= srst ? 1'b0 : frameS;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      llPending <= 1'b0;
      llCnt <= '0;
      lineLoadPulse <= 1'b0;
    end else if (lineDoneRise) begin
      llPending <= 1'b1;
      llCnt <= '0;
    end else if (llPending) begin
      if (llCnt >= llDelay) begin
        llPending <= 1'b0;
        lineLoadPulse <= 1'b1;
        llCnt <= '0;
      end else begin
        llCnt <= incSat(llCnt);
      end
    end else if (lineLoadPulse) begin
      if (llCnt + 1'b1 >= llWidth) begin
        lineLoadPulse <= 1'b0;
      end
      llCnt <= incSat(llCnt);
    end
  end

  wire llStart = llPending && (llCnt >= llDelay);
  // starts negative at line done so edges may lead the line load by up to the delay
  always_ff @(posedge mclk) begin
    if (srst) begin
      pos <= POS_ZERO;
    end else if (lineDoneRise) begin
      pos <= -$signed(llDelay);
    end else if (llStart) begin
      pos <= POS_ONE;
    end else if (pos != POS_MAX) begin
      pos <= pos + POS_ONE;
    end
  end
  wire signed [W-1:0] posNow = llStart ? POS_ZERO : pos;

  // power-on start timers
  logic [W-1:0] powerCnt;
  always_ff @(posedge mclk) begin
    if (srst) begin
      powerCnt <= '0;
    end else begin
      powerCnt <= incSat(powerCnt);
    end
  end
  wire sclkRun = ctrl[CTRL_ENABLE] && (powerCnt >= startCfg[W-1:0]);
  wire convGo = powerCnt >= startCfg[16 +: W];

  // line counter inside the frame
  logic [W-1:0] lineNum;
  always_ff @(posedge mclk) begin
    if (srst || frameRise) begin
      lineNum <= '0;
    end else if (llStart) begin
      lineNum <= incSat(lineNum);
    end
  end

  function automatic logic strobeOn(input logic [W-1:0] ln, input pgc_strobe_t s);
    strobeOn = (ln >= s.line[W-1:0]) && ((ln - s.line[W-1:0]) < s.width[W-1:0]);
  endfunction : strobeOn

  // general output edges are 15-bit signed fields, widened with their sign
  localparam int GPO_EDGE_W = GPO_MODE_LSB / 2;
  function automatic pgc_edge_t gpoEdges(input logic [31:0] c);
    gpoEdges.fall = {{(CNT_W-GPO_EDGE_W){c[2*GPO_EDGE_W-1]}}, c[GPO_EDGE_W +: GPO_EDGE_W]};
    gpoEdges.rise = {{(CNT_W-GPO_EDGE_W){c[GPO_EDGE_W-1]}}, c[GPO_EDGE_W-1:0]};
  endfunction : gpoEdges

  // edge generators
  logic sclkWave, oenWave, gpo1Wave, gpo2Wave;
  wire oePol = ctrl[CTRL_OE_POL];

  pgc_edge_gen #(.W(W)) uShift (
    .mclk(mclk), .srst(srst), .run(sclkRun), .invert(1'b0),
    .pos(posNow), .edges(pgc_edge_t'(sclkCfg)), .wave(sclkWave)
  );
  pgc_edge_gen #(.W(W)) uOen (
    .mclk(mclk), .srst(srst), .run(ctrl[CTRL_ENABLE]), .invert(oePol),
    .pos(posNow), .edges(pgc_edge_t'(oenCfg)), .wave(oenWave)
  );
  pgc_edge_gen #(.W(W)) uGpo1 (
    .mclk(mclk), .srst(srst), .run(ctrl[CTRL_ENABLE]), .invert(1'b0),
    .pos(posNow), .edges(gpoEdges(gpo1Cfg)), .wave(gpo1Wave)
  );
  pgc_edge_gen #(.W(W)) uGpo2 (
    .mclk(mclk), .srst(srst), .run(ctrl[CTRL_ENABLE]), .invert(1'b0),
    .pos(posNow), .edges(gpoEdges(gpo2Cfg)), .wave(gpo2Wave)
  );

  function automatic logic gpoSel(input logic [1:0] m, input logic edgeWave,
      input logic frm, input logic conv, input logic lvl);
    case (pgc_gpo_mode_t'(m))
      GPO_OE2: gpoSel = edgeWave;
      GPO_FRAME: gpoSel = frm;
      GPO_CONV: gpoSel = conv;
      GPO_LEVEL: gpoSel = lvl;
      default: gpoSel = 1'b0;
    endcase
  endfunction : gpoSel

  // lines are numbered from one after the frame start
  wire firstLine = (lineNum == {{(W-1){1'b0}}, 1'b1});
  always_ff @(posedge mclk) begin
    if (srst) begin
      gateOut <= '0;
      gateOut.outEnable <= RST_CTRL[CTRL_OE_POL];
    end else begin
      gateOut.shiftClk <= sclkWave;
      gateOut.outEnable <= ctrl[CTRL_ENABLE] ? oenWave : oePol;
      gateOut.strobeA <= strobeOn(lineNum, pgc_strobe_t'(stbaCfg));
      gateOut.strobeB <= strobeOn(lineNum, pgc_strobe_t'(stbbCfg));
      gateOut.genOne <= gpoSel(gpo1Cfg[GPO_MODE_LSB +: 2], gpo1Wave, firstLine,
                               convGo, gpo1Cfg[0]);
      gateOut.genTwo <= gpoSel(gpo2Cfg[GPO_MODE_LSB +: 2], gpo2Wave, firstLine,
                               convGo, gpo2Cfg[0]);
      gateOut.convStart <= convGo;
    end
  end

  // wishbone slave, one wait state, ack drops after one cycle
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire hitCtrl = wb_adr_i == REG_CTRL;
  wire hitLine = wb_adr_i == REG_LINE;
  wire hitSclk = wb_adr_i == REG_SCLK;
  wire hitOen = wb_adr_i == REG_OEN;
  wire hitStba = wb_adr_i == REG_STBA;
  wire hitStbb = wb_adr_i == REG_STBB;
  wire hitGpo1 = wb_adr_i == REG_GPO1;
  wire hitGpo2 = wb_adr_i == REG_GPO2;
  wire hitStart = wb_adr_i == REG_START;
  wire hitStat = wb_adr_i == REG_STAT;
  wire mapped = hitCtrl | hitLine | hitSclk | hitOen | hitStba | hitStbb | hitGpo1
              | hitGpo2 | hitStart | hitStat;
  wire wr = req && wb_we_i && mapped;
  wire [31:0] statWord = {8'h00, 8'(lineNum), 8'h00, 1'b0, testMode, patternMode,
                          convGo, sclkRun, loopback, lineLoadPulse, llPending};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
      input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  wire [31:0] rdMux = hitCtrl ? ctrl : hitLine ? lineCfg : hitSclk ? sclkCfg :
                      hitOen ? oenCfg : hitStba ? stbaCfg : hitStbb ? stbbCfg :
                      hitGpo1 ? gpo1Cfg : hitGpo2 ? gpo2Cfg : hitStart ? startCfg :
                      hitStat ? statWord : 32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl <= RST_CTRL;
      lineCfg <= RST_LINE;
      sclkCfg <= RST_SCLK;
      oenCfg <= RST_OEN;
      stbaCfg <= RST_STB;
      stbbCfg <= RST_STB;
      gpo1Cfg <= RST_GPO;
      gpo2Cfg <= RST_GPO;
      startCfg <= RST_START;
    end else if (wr) begin
      if (hitCtrl) ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
      if (hitLine) lineCfg <= merge(lineCfg, wb_dat_i, wb_sel_i);
      if (hitSclk) sclkCfg <= merge(sclkCfg, wb_dat_i, wb_sel_i);
      if (hitOen) oenCfg <= merge(oenCfg, wb_dat_i, wb_sel_i);
      if (hitStba) stbaCfg <= merge(stbaCfg, wb_dat_i, wb_sel_i);
      if (hitStbb) stbbCfg <= merge(stbbCfg, wb_dat_i, wb_sel_i);
      if (hitGpo1) gpo1Cfg <= merge(gpo1Cfg, wb_dat_i, wb_sel_i);
      if (hitGpo2) gpo2Cfg <= merge(gpo2Cfg, wb_dat_i, wb_sel_i);
      if (hitStart) startCfg <= merge(startCfg, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
      wb_dat_o <= (req && !wb_we_i) ? rdMux : 32'h0000_0000;
    end
  end
endmodule : pgc_gate_timing
`default_nettype wire

// ---- src/pgc_pkg.sv ----
// pgc_pkg: register map, field layouts and shared types for the panel gate control block
// assumes a classic wishbone slave with 32-bit data and byte addresses
package pgc_pkg;

  localparam int CNT_W = 16;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LINE = 8'h04;
  localparam logic [7:0] REG_SCLK = 8'h08;
  localparam logic [7:0] REG_OEN = 8'h0C;
  localparam logic [7:0] REG_STBA = 8'h10;
  localparam logic [7:0] REG_STBB = 8'h14;
  localparam logic [7:0] REG_GPO1 = 8'h18;
  localparam logic [7:0] REG_GPO2 = 8'h1C;
  localparam logic [7:0] REG_START = 8'h20;
  localparam logic [7:0] REG_STAT = 8'h24;

  // control register fields
  localparam int CTRL_LOOPBACK = 0;
  localparam int CTRL_OE_POL = 1;
  localparam int CTRL_ENABLE = 2;

  // general output mode field position; the mode field is two bits wide
  localparam int GPO_MODE_LSB = 30;

  // reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0004;
  localparam logic [31:0] RST_LINE = 32'h0004_0020;
  localparam logic [31:0] RST_SCLK = 32'h0004_FFFC;
  localparam logic [31:0] RST_OEN = 32'h0006_FFFE;
  localparam logic [31:0] RST_STB = 32'h0000_0001;
  localparam logic [31:0] RST_GPO = 32'h0000_0000;
  localparam logic [31:0] RST_START = 32'h0040_0040;

  // general output modes
  typedef enum logic [1:0] {
    GPO_OE2 = 2'h0,
    GPO_FRAME = 2'h1,
    GPO_CONV = 2'h2,
    GPO_LEVEL = 2'h3
  } pgc_gpo_mode_t;

  // signed edge window relative to the line load rising edge
  typedef struct packed {
    logic signed [CNT_W-1:0] fall;
    logic signed [CNT_W-1:0] rise;
  } pgc_edge_t;

  // gate strobe: start line, width in lines
  typedef struct packed {
    logic [CNT_W-1:0] width;
    logic [CNT_W-1:0] line;
  } pgc_strobe_t;

  // gate control outputs grouped
  typedef struct packed {
    logic shiftClk;
    logic outEnable;
    logic strobeA;
    logic strobeB;
    logic genOne;
    logic genTwo;
    logic convStart;
  } pgc_gate_t;

  // wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } pgc_wb_req_t;

endpackage : pgc_pkg

// ---- src/pgc_edge_gen.sv ----
// pgc_edge_gen: one waveform whose edges sit at signed offsets from a line reference
// assumes a free-running signed position counter that is zero at the line load rise
`timescale 1ns/100ps
`default_nettype none
module pgc_edge_gen
  import pgc_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic run,
  input wire logic invert,
  input wire logic signed [W-1:0] pos,
  input wire pgc_pkg::pgc_edge_t edges,
  output logic wave
);
  import pgc_pkg::*;

  initial begin
    if (W != CNT_W) $error("pgc_edge_gen: W must equal CNT_W");
  end

  logic active;
  wire hitRise = (pos == edges.rise);
  wire hitFall = (pos == edges.fall);

  // signed offsets from the line load edge
  always_ff @(posedge mclk) begin
    if (srst || !run) begin
      active <= 1'b0;
    end else if (hitRise) begin
      active <= 1'b1;
    end else if (hitFall) begin
      active <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wave <= 1'b0;
    end else begin
      wave <= active ^ invert;
    end
  end
endmodule : pgc_edge_gen
`default_nettype wire

// ---- bench/pgc_gate_timing_chk.sv ----
// pgc_gate_timing_chk: port assertions for the gate timing block
// assumes line and start registers keep their reset values
`timescale 1ns/100ps
`default_nettype none
module pgc_gate_timing_chk
  import pgc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic lineDone,
  input wire logic testPin,
  input wire logic recoveredClockIn,
  input wire logic lineLoadPulse,
  input wire pgc_pkg::pgc_gate_t gateOut,
  input wire logic patternMode,
  input wire logic testMode,
  input wire logic recoveredClockOutput,
  input wire logic recoveredClockOutputEn,
  input wire logic dotClockSelect
);
  logic [7:0] age;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // cycles since reset release, saturating
  always_ff @(posedge mclk) begin
    if (srst) age <= 8'h00;
    else if (age != 8'hFF) age <= age + 8'h01;
  end
  sequence doneRise;
    $rose(lineDone);
  endsequence
  sequence loadRise;
    ##[6:10] $rose(lineLoadPulse);
  endsequence
  loadAfter_a: assert property (doneRise |-> loadRise)
    else $error("line load not after line done");
  convEarly_a: assert property (age < 8'h3C |-> !gateOut.convStart)
    else $error("converter start too early");
  shiftEarly_a: assert property (age < 8'h3C |-> !gateOut.shiftClk)
    else $error("shift clock too early");
  strapHold_a: assert property (age > 8'h03 |-> $stable(patternMode))
    else $error("pattern mode changed");
  testSync_a: assert property
    ((age > 8'h06) ##0 $stable(testPin)[*5] |-> testMode == testPin)
    else $error("test mode not following pin");
  clkPass_a: assert property
    (recoveredClockOutputEn |-> recoveredClockOutput == recoveredClockIn)
    else $error("recovered clock not passed out");
  clkQuiet_a: assert property (!recoveredClockOutputEn |-> !recoveredClockOutput)
    else $error("output buffer active in loopback");
  loopSel_a: assert property (dotClockSelect == !recoveredClockOutputEn)
    else $error("loopback select mismatch");
endmodule : pgc_gate_timing_chk
bind pgc_gate_timing pgc_gate_timing_chk chk (
  .mclk(mclk), .srst(srst), .lineDone(lineDone), .testPin(testPin),
  .recoveredClockIn(recoveredClockIn), .lineLoadPulse(lineLoadPulse), .gateOut(gateOut),
  .patternMode(patternMode), .testMode(testMode), .recoveredClockOutput(recoveredClockOutput),
  .recoveredClockOutputEn(recoveredClockOutputEn), .dotClockSelect(dotClockSelect)
);
`default_nettype wire

// ---- bench/pgc_panel_model.sv ----
// pgc_panel_model: gate driver shift register on the panel side
// assumes gate outputs arrive registered on the dot clock
`timescale 1ns/100ps
`default_nettype none
module pgc_panel_model
  import pgc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire pgc_pkg::pgc_gate_t gateOut,
  output logic [15:0] rowCount
);
  logic lastShift;
  // one row advance per shift clock rise
  always_ff @(posedge mclk) begin
    lastShift <= gateOut.shiftClk;
    if (srst) rowCount <= 16'h0000;
    else if (gateOut.shiftClk && !lastShift) rowCount <= rowCount + 16'h0001;
  end
endmodule : pgc_panel_model
`default_nettype wire

// ---- bench/testbench.sv ----
// testbench: drives the gate timing block over its bus and line inputs
// assumes the bound checker and the panel model sit beside it
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pgc_pkg::*;
  localparam int LP = 128;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic lineDone = 1'b0;
  logic frameStart = 1'b0;
  logic strap = 1'b0;
  logic testPin = 1'b0;
  logic rci = 1'b0;
  logic [9:0] lc = 10'h000;
  logic [31:0] datO;
  logic ack, err, llp, patternMode, testMode, rco, rcoEn, dcs;
  logic [15:0] rowCount;
  pgc_gate_t gateOut;
  logic [6:0] g;
  int bad_count = 0;
  int check_count = 0;
  int tick = 0;
  assign g = gateOut;
  always #5 mclk = ~mclk;
  // line and frame timing, recovered clock, timeout
  always @(posedge mclk) begin
    lc <= lc + 10'h001;
    lineDone <= lc[6:0] < 7'h14;
    frameStart <= lc < 10'h014;
    rci <= ~rci;
    tick <= tick + 1;
    if (tick == 32'h0000_9C40) begin
      bad_count++;
      end_sim();
    end
  end
  pgc_gate_timing dut (
    .mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .wb_err_o(err),
    .lineDone(lineDone), .frameStart(frameStart), .burnInPatternStrap(strap),
    .testPin(testPin), .recoveredClockIn(rci), .spreadClockInput(rci), .lineLoadPulse(llp),
    .gateOut(gateOut), .patternMode(patternMode), .testMode(testMode),
    .recoveredClockOutput(rco), .recoveredClockOutputEn(rcoEn), .dotClockSelect(dcs)
  );
  pgc_panel_model model (.mclk(mclk), .srst(srst), .gateOut(gateOut), .rowCount(rowCount));
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  function automatic int span(input int r, input int f);
    return f - r;
  endfunction : span
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    @(posedge mclk);
    while (ack !== 1'b1 && err !== 1'b1) @(posedge mclk);
    q = datO;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic wr(input int a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    bus(1'b1, 8'(a), d, q, e);
  endtask : wr
  // length of the next full high pulse on one gate output
  task automatic width(input int i, output int n);
    int k;
    k = 0;
    n = 0;
    while (g[i] !== 1'b0 && k < 3000) begin
      @(posedge mclk);
      k++;
    end
    while (g[i] !== 1'b1 && k < 6000) begin
      @(posedge mclk);
      k++;
    end
    while (g[i] === 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
  endtask : width
  initial begin
    int r, w, n, a;
    logic [31:0] q;
    logic e;
    logic [15:0] s;
    void'($urandom(32'h0000_20CD));
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    check("pattern", {31'h0, patternMode}, 32'h1);
    strap <= 1'b1;
    bus(1'b0, 8'h28, 32'h0, q, e);
    check("unmapped err", {31'h0, e}, 32'h1);
    check("unmapped data", q, 32'h0);
    check("strap held", {31'h0, patternMode}, 32'h1);
    wr(REG_CTRL, 32'h0000_0005);
    repeat (3) @(posedge mclk);
    check("loopback", {29'h0, dcs, rcoEn, rco}, 32'h4);
    for (int p = 0; p < 2; p++) begin
      wr(REG_CTRL, 32'(p * 2));
      repeat (4) @(posedge mclk);
      check("oe idle", {31'h0, g[5]}, 32'(p));
    end
    wr(REG_CTRL, 32'h0000_0004);
    for (int k = 0; k < 5; k++) begin
      r = (k == 0) ? -1 : -int'($urandom % 4) - 1;
      w = (k == 0) ? 1 : int'($urandom % 30) + 1;
      wr(REG_SCLK, {16'(r + w), 16'(r)});
      wr(REG_OEN, {16'(r + w + 2), 16'(r + 1)});
      width(6, n);
      check("sclk width", 32'(n), 32'(span(r, r + w)));
      width(5, n);
      check("oe width", 32'(n), 32'(span(r + 1, r + w + 2)));
    end
    s = rowCount;
    repeat (4 * LP) @(posedge mclk);
    check("rows", 32'(rowCount - s), 32'h4);
    for (int i = 0; i < 2; i++) begin
      w = int'($urandom % 3) + 1;
      wr(REG_STBA + 4 * i, {16'(w), 16'(($urandom % 3) + 1)});
      width(4 - i, n);
      check("strobe width", 32'(n), 32'(w * LP));
    end
    for (int i = 0; i < 2; i++) begin
      a = REG_GPO1 + 4 * i;
      wr(a, {2'h0, 15'h0005, 15'h7FFD});
      width(2 - i, n);
      check("gpo oe2", 32'(n), 32'(span(-3, 5)));
      wr(a, 32'h4000_0000);
      width(2 - i, n);
      check("gpo frame", 32'(n), 32'(LP));
      for (int v = 0; v < 2; v++) begin
        wr(a, 32'hC000_0000 | 32'(v));
        repeat (3) @(posedge mclk);
        check("gpo level", {31'h0, g[2 - i]}, 32'(v));
      end
      wr(a, 32'h8000_0000);
      repeat (2) @(posedge mclk);
      check("gpo conv", {31'h0, g[2 - i]}, 32'h1);
    end
    check("conv on", {31'h0, g[0]}, 32'h1);
    testPin <= 1'b1;
    repeat (8) @(posedge mclk);
    check("test mode", {31'h0, testMode}, 32'h1);
    testPin <= 1'b0;
    repeat (8) @(posedge mclk);
    check("normal mode", {31'h0, testMode}, 32'h0);
    srst <= 1'b1;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    n = 0;
    while (g[0] !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    check("pattern off", {31'h0, patternMode}, 32'h0);
    check("conv delay", 32'(n >= 60 && n < 300), 32'h1);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
